// File: logic/gcc_consts.svh
// Behaviour
// - hb4 source code bits 7-4, resets ones
// - hb4 sink code bits 3-0, resets ones
// - codes index sixteen-step current table
// - per-bridge low-current select bits 7-4
// - cleared select bit means standard table
// - hb4 register at 12h, reset FFh
// - select register at 17h, reset zero
`ifndef GCC_CONSTS_SVH
`define GCC_CONSTS_SVH

// ======================================================
// register map
`define GCC_ADDR_W          8
`define GCC_DATA_W          8
`define GCC_OFF_HB4_CURRENT 8'h12
`define GCC_OFF_LOW_SELECT  8'h17
`define GCC_RST_HB4_CURRENT 8'hff
`define GCC_RST_LOW_SELECT  8'h00

// ======================================================
// field layout
`define GCC_SOURCE_MSB      7
`define GCC_SOURCE_LSB      4
`define GCC_SINK_MSB        3
`define GCC_SINK_LSB        0
`define GCC_SEL_MSB         7
`define GCC_SEL_LSB         4
`define GCC_SEL_RSVD        4'h0
`define GCC_HB4_WRITE_MASK  8'hff
`define GCC_SEL_WRITE_MASK  8'hf0
`define GCC_NUM_BRIDGES     4

`endif

// File: logic/gcc_pkg.sv
`include "gcc_consts.svh"
package gcc_pkg;
   typedef struct packed {
      logic [3:0] source_current_code;
      logic [3:0] sink_current_code;
   } gcc_codes_t;

   typedef struct packed {
      gcc_codes_t codes;
      logic       low_current_sel;
   } gcc_drive_t;

   // per-bridge select, index 0 is half-bridge 1
   typedef logic [`GCC_NUM_BRIDGES-1:0] gcc_sel_t;
endpackage

// File: logic/gcc_reg8.sv
`timescale 1ns/1ps
`default_nettype none
`include "gcc_consts.svh"
module gcc_reg8 #(
   parameter logic [7:0] RESET_VALUE = 8'h00,
   parameter logic [7:0] WRITE_MASK  = 8'hff
) (
   input  wire logic       ref_clk_in,
   input  wire logic       reset_in,
   input  wire logic       wr_en_in,
   input  wire logic [7:0] wr_data_in,
   output logic      [7:0] value_out
);
   logic [7:0] value;
   logic [7:0] next_value;

   always_comb begin
      next_value = value;
      if (wr_en_in) begin
         // masked bits keep their reset value forever
         next_value = (wr_data_in & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         value <= RESET_VALUE;
      end else begin
         value <= next_value;
      end
   end

   assign value_out = value;
endmodule
`default_nettype wire

// File: logic/gcc_regs.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "gcc_consts.svh"
module gcc_regs
   import gcc_pkg::*;
(
   input  wire logic                   ref_clk_in,
   input  wire logic                   reset_in,
   input  wire logic [`GCC_ADDR_W-1:0] addr_in,
   input  wire logic [`GCC_DATA_W-1:0] wr_data_in,
   input  wire logic                   wr_in,
   input  wire logic                   rd_in,
   output logic      [`GCC_DATA_W-1:0] rd_data_out,
   output gcc_drive_t                  hb4_drive_out,
   output gcc_sel_t                    low_current_sel_out
);
   // ======================================================
   // storage
   logic [7:0] hb4_current;
   logic [7:0] low_select;
   logic       wr_hb4;
   logic       wr_sel;

   assign wr_hb4 = wr_in && (addr_in == `GCC_OFF_HB4_CURRENT);
   assign wr_sel = wr_in && (addr_in == `GCC_OFF_LOW_SELECT);

   gcc_reg8 #(
      .RESET_VALUE (`GCC_RST_HB4_CURRENT),
      .WRITE_MASK  (`GCC_HB4_WRITE_MASK)
   ) u_hb4 (
      .ref_clk_in  (ref_clk_in),
      .reset_in    (reset_in),
      .wr_en_in    (wr_hb4),
      .wr_data_in  (wr_data_in),
      .value_out   (hb4_current)
   );

   // low nibble write-masked so it stays zero
   gcc_reg8 #(
      .RESET_VALUE (`GCC_RST_LOW_SELECT),
      .WRITE_MASK  (`GCC_SEL_WRITE_MASK)
   ) u_sel (
      .ref_clk_in  (ref_clk_in),
      .reset_in    (reset_in),
      .wr_en_in    (wr_sel),
      .wr_data_in  (wr_data_in),
      .value_out   (low_select)
   );

   // ======================================================
   // read port, data one cycle after the strobe
   logic [7:0] rd_data;
   logic [7:0] next_rd_data;

   always_comb begin
      next_rd_data = 8'h00;
      if (rd_in) begin
         case (addr_in)
            `GCC_OFF_HB4_CURRENT: next_rd_data = hb4_current;
            `GCC_OFF_LOW_SELECT:  next_rd_data =
               {low_select[`GCC_SEL_MSB:`GCC_SEL_LSB], `GCC_SEL_RSVD};
            default:              next_rd_data = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= next_rd_data;
      end
   end

   assign rd_data_out = rd_data;

   // ======================================================
   // analog stage controls; the select bit picks the table per bridge
   // bit 7 is half-bridge 1, so reverse into index 0 = bridge 1
   always_comb begin
      for (int i = 0; i < `GCC_NUM_BRIDGES; i++) begin
         low_current_sel_out[i] = low_select[`GCC_SEL_MSB - i];
      end
   end

   assign hb4_drive_out.codes.source_current_code =
      hb4_current[`GCC_SOURCE_MSB:`GCC_SOURCE_LSB];
   assign hb4_drive_out.codes.sink_current_code =
      hb4_current[`GCC_SINK_MSB:`GCC_SINK_LSB];
   assign hb4_drive_out.low_current_sel = low_select[`GCC_SEL_LSB];

   // ======================================================
   // checks
   a_hb4_write_lands: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      wr_hb4 |=> hb4_current == $past(wr_data_in))
      else $error("hb4 current write not stored");

   a_sel_write_lands: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      wr_sel |=> low_select[7:4] == $past(wr_data_in[7:4]))
      else $error("select write not stored");

   a_rsvd_zero_read: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      (rd_in && addr_in == `GCC_OFF_LOW_SELECT) |=> rd_data_out[3:0] == 4'h0)
      else $error("reserved bits read nonzero");

   a_hb4_read_back: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      (rd_in && addr_in == `GCC_OFF_HB4_CURRENT) |=>
         rd_data_out == {hb4_drive_out.codes.source_current_code,
                         hb4_drive_out.codes.sink_current_code})
      else $error("hb4 read mismatch");

   a_sink_field_map: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      wr_hb4 |=> hb4_drive_out.codes.sink_current_code
                 == $past(wr_data_in[3:0]))
      else $error("sink code field misplaced");

   a_hb1_sel_map: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      wr_sel |=> low_current_sel_out[0] == $past(wr_data_in[7]))
      else $error("bridge 1 select misplaced");

   a_unmapped_zero: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      (rd_in && addr_in != `GCC_OFF_HB4_CURRENT
             && addr_in != `GCC_OFF_LOW_SELECT) |=> rd_data_out == 8'h00)
      else $error("unmapped read nonzero");

   a_hb4_holds: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      !wr_hb4 |=> $stable(hb4_current))
      else $error("hb4 changed without write");

   // reset is released by the bench on an edge, so the first edge with
   // reset low sees the reset values before any write can land
   a_hb4_reset_value: assert property (@(posedge ref_clk_in)
      $fell(reset_in) |-> hb4_current == `GCC_RST_HB4_CURRENT)
      else $error("hb4 reset value wrong");

   a_sel_reset_value: assert property (@(posedge ref_clk_in)
      $fell(reset_in) |-> low_select == `GCC_RST_LOW_SELECT)
      else $error("select reset value wrong");

   a_rsvd_never_set: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      low_select[`GCC_SEL_LSB-1:0] == `GCC_SEL_RSVD)
      else $error("reserved select bits set");

   a_sel_holds: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      !wr_sel |=> $stable(low_select))
      else $error("select changed without write");

   a_source_field_map: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      wr_hb4 |=> hb4_drive_out.codes.source_current_code
                 == $past(wr_data_in[`GCC_SOURCE_MSB:`GCC_SOURCE_LSB]))
      else $error("source code field misplaced");

   a_hb4_sel_map: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      hb4_drive_out.low_current_sel
         == low_current_sel_out[`GCC_NUM_BRIDGES-1])
      else $error("bridge 4 select mismatch");

   a_sel_read_back: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      (rd_in && addr_in == `GCC_OFF_LOW_SELECT) |=>
         rd_data_out[`GCC_SEL_MSB:`GCC_SEL_LSB]
            == $past(low_select[`GCC_SEL_MSB:`GCC_SEL_LSB]))
      else $error("select read mismatch");

   a_rd_idle_zero: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      !rd_in |=> rd_data_out == '0)
      else $error("read data without read");

   a_unmapped_no_write: assert property (@(posedge ref_clk_in)
      disable iff (reset_in)
      (wr_in && addr_in != `GCC_OFF_HB4_CURRENT
             && addr_in != `GCC_OFF_LOW_SELECT) |=>
         ($stable(hb4_current) && $stable(low_select)))
      else $error("unmapped write changed state");
endmodule
`default_nettype wire

// File: verif/gcc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gcc_regs_tb
   import gcc_pkg::*;
;
   logic            ref_clk_in;
   logic            reset_in;
   logic            wr_in;
   logic            rd_in;
   logic      [7:0] addr_in;
   logic      [7:0] wr_data_in;
   logic      [7:0] e12;
   logic      [7:0] e17;
   logic      [7:0] erd;
   logic     [31:0] r;
   wire logic [7:0] rd_data_out;
   gcc_drive_t      drive;
   gcc_sel_t        sel;
   int              err_count = 0;
   int              checks_done = 0;
   int              cycles = 0;
   int              seed = 39088;

   gcc_regs gcc_regs_inst (
      .ref_clk_in          (ref_clk_in),
      .reset_in            (reset_in),
      .addr_in             (addr_in),
      .wr_data_in          (wr_data_in),
      .wr_in               (wr_in),
      .rd_in               (rd_in),
      .rd_data_out         (rd_data_out),
      .hb4_drive_out       (drive),
      .low_current_sel_out (sel)
   );

   // ==========================================
   // checking
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // drive on the edge; at the falling edge outputs show the previous op
   task automatic cyc(input logic w, input logic rd, input logic [7:0] a,
                      input logic [7:0] d);
      @(posedge ref_clk_in);
      wr_in <= w;
      rd_in <= rd;
      addr_in <= a;
      wr_data_in <= d;
      @(negedge ref_clk_in);
      chk({4'h0, drive.codes.source_current_code}, {4'h0, e12[7:4]});
      chk({4'h0, drive.codes.sink_current_code}, {4'h0, e12[3:0]});
      chk({7'h0, drive.low_current_sel}, {7'h0, e17[4]});
      chk({4'h0, sel}, {4'h0, e17[4], e17[5], e17[6], e17[7]});
      chk(rd_data_out, erd);
      erd = !rd ? 8'h00 : (a == 8'h12) ? e12 : (a == 8'h17) ? e17 : 8'h00;
      if (w && a == 8'h12) e12 = d;
      if (w && a == 8'h17) e17 = d & 8'hf0;
   endtask

   task automatic rst();
      reset_in <= 1'b1;
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      e12 = 8'hff;
      e17 = 8'h00;
      erd = 8'h00;
   endtask

   // ==========================================
   // clock and hang guard
   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end

   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         err_count++;
         results();
      end
   end

   // ==========================================
   // scenarios
   initial begin
      {reset_in, wr_in, rd_in, addr_in, wr_data_in} = '0;
      rst();
      cyc(0, 1, 8'h12, 8'h00);
      cyc(0, 1, 8'h17, 8'h00);
      $display("test reset_values done");
      // reserved nibble, unmapped write and read, back to back
      cyc(1, 0, 8'h17, 8'hff);
      cyc(0, 1, 8'h17, 8'h00);
      cyc(1, 0, 8'h12, 8'h00);
      cyc(1, 0, 8'h13, 8'h5a);
      cyc(0, 1, 8'h12, 8'h00);
      cyc(0, 1, 8'h16, 8'h00);
      $display("test corners done");
      repeat (400) begin
         r = $random(seed);
         cyc(r[8], !r[8] & r[9], r[10] ? (r[11] ? 8'h12 : 8'h17) : r[7:0],
             r[23:16]);
      end
      cyc(0, 0, 8'h00, 8'h00);
      cyc(0, 0, 8'h00, 8'h00);
      $display("test random done");
      cyc(1, 0, 8'h12, 8'h3c);
      rst();
      cyc(0, 1, 8'h12, 8'h00);
      cyc(0, 0, 8'h00, 8'h00);
      cyc(0, 0, 8'h00, 8'h00);
      $display("test mid_reset done");
      results();
   end
endmodule
`default_nettype wire
